// file: ppsd_pkg.sv
// ----------------------------------------
// Port pin sense and direction constants
// ----------------------------------------
package ppsd_pkg;

  localparam int unsigned NPIN   = 8;     // Pins per port
  localparam int unsigned ADDR_W = 8;     // Register address width
  localparam int unsigned DATA_W = 8;     // Register data width

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_DIR      = 8'h00;  // Direction
  localparam logic [7:0] OFS_DIR_SET  = 8'h01;  // Direction set alias
  localparam logic [7:0] OFS_DIR_CLR  = 8'h02;  // Direction clear alias
  localparam logic [7:0] OFS_DIR_TGL  = 8'h03;  // Direction toggle alias
  localparam logic [7:0] OFS_IRQ_EN   = 8'h09;  // Interrupt enables
  localparam logic [7:0] OFS_MASK_A   = 8'h0a;  // Interrupt A pin mask
  localparam logic [7:0] OFS_MASK_B   = 8'h0b;  // Interrupt B pin mask
  localparam logic [7:0] OFS_FLAGS    = 8'h0c;  // Interrupt flags
  localparam logic [7:0] OFS_CFG_BASE = 8'h10;  // Pin config, pin 0
  localparam logic [7:0] OFS_CFG_MASK = 8'h20;  // Multi-pin config mask
  localparam logic [7:0] OFS_OUTSEL   = 8'h21;  // Clock/event output
  localparam logic [7:0] OFS_VMAP     = 8'h30;  // Virtual port map 0..3
  localparam logic [7:0] OFS_VWIN     = 8'h40;  // Virtual window base
  localparam logic [7:0] OFS_NONE     = 8'hff;  // Decoder miss

  // ----------------------------------------
  // Field positions and codes
  // ----------------------------------------
  localparam int unsigned CFG_SNS_LSB = 0;      // Sense field low bit
  localparam int unsigned CFG_INV_BIT = 6;      // Inverted input bit
  localparam int unsigned OSEL_PIN_LSB = 0;     // Output pin select
  localparam int unsigned OSEL_EVT_BIT = 6;     // Event channel 0 out
  localparam int unsigned OSEL_CLK_BIT = 7;     // Clock out
  localparam int unsigned FULL_ASYNC_PIN = 2;   // Full async pin
  localparam logic [2:0] SNS_BOTH = 3'h0;       // Any edge
  localparam logic [2:0] SNS_RISE = 3'h1;       // Rising edge
  localparam logic [2:0] SNS_FALL = 3'h2;       // Falling edge
  localparam logic [2:0] SNS_LOW  = 3'h3;       // Low level
  localparam logic [7:0] RST_BYTE = 8'h00;      // Register reset value
  localparam logic [7:0] PORT_ID  = 8'h01;      // Arbitrary port number

endpackage : ppsd_pkg

// file: ppsd_sense.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Per-pin sense evaluation
// ----------------------------------------
module ppsd_sense #(
  parameter bit FULL_ASYNC = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       cur,
  input  wire logic       prev_run,
  input  wire logic       prev_all,
  input  wire logic       clk_run,
  input  wire logic [2:0] sense,
  output logic            irq_hit,
  output logic            evt_sig,
  output logic            wake
);
  import ppsd_pkg::*;

  logic latch_ff;     // Edge caught while clock stopped
  logic rise_r;       // Rise against last clocked sample
  logic fall_r;       // Fall against last clocked sample
  logic edge_a;       // Edge against every-cycle sample
  logic low;          // Low-level match

  // Pick the condition named by the sense code
  function automatic logic sel(input logic [2:0] s, input logic r,
                               input logic f, input logic l);
    unique case (s)
      SNS_BOTH: sel = r | f;
      SNS_RISE: sel = r;
      SNS_FALL: sel = f;
      SNS_LOW:  sel = l;
      default:  sel = 1'b0;  // Unused codes sense nothing
    endcase
  endfunction : sel

  always_comb begin
    rise_r = !prev_run & cur;
    fall_r = prev_run & !cur;
    edge_a = sel(sense, !prev_all & cur, prev_all & !cur, 1'b0);
    low    = (sense == SNS_LOW) & !cur;
  end

  // Only the full async pin latches a transient edge; others lose it
  always_ff @(posedge clk) begin
    if (!rst_n || !FULL_ASYNC || clk_run) begin
      latch_ff <= 1'b0;
    end else if (edge_a) begin
      latch_ff <= 1'b1;
    end
  end

  // Edges count only once sampled on the running clock
  assign irq_hit = clk_run & (sel(sense, rise_r, fall_r, !cur)
                              | latch_ff);
  // Events never appear while the clock is stopped
  assign evt_sig = clk_run & sel(sense, rise_r, fall_r, cur);
  // Limited pins wake on any-edge or low only; a reverted edge is lost
  assign wake = !clk_run & (FULL_ASYNC ? (latch_ff | low)
              : (((sense == SNS_BOTH) & (cur != prev_run)) | low));

endmodule : ppsd_sense
`default_nettype wire

// file: ppsd_port.sv
`timescale 1ns/10ps
`default_nettype none
module ppsd_port (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic [ppsd_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ppsd_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [ppsd_pkg::DATA_W-1:0]   reg_rdata,
  input  wire logic [ppsd_pkg::NPIN-1:0] pin_in,
  output logic [ppsd_pkg::NPIN-1:0]     pin_out,
  output logic [ppsd_pkg::NPIN-1:0]     pin_oe,
  input  wire logic [ppsd_pkg::NPIN-1:0] port_out_val,
  input  wire logic                     clk_run,
  input  wire logic [ppsd_pkg::NPIN-1:0] ovr_oe_en,
  input  wire logic [ppsd_pkg::NPIN-1:0] ovr_oe_val,
  input  wire logic [ppsd_pkg::NPIN-1:0] ovr_out_en,
  input  wire logic [ppsd_pkg::NPIN-1:0] ovr_out_val,
  input  wire logic                     evt_ch0,
  output logic                          irq_a,
  output logic                          irq_b,
  output logic                          wake_req,
  output logic [ppsd_pkg::NPIN-1:0]     evt_sig,
  output logic [ppsd_pkg::NPIN-1:0]     evt_data
);
  import ppsd_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [NPIN-1:0] dir_ff;             // Pin direction
  logic [1:0]      irq_en_ff;          // Interrupt enables, A in bit 0
  logic [NPIN-1:0] mask_a_ff;          // Pins feeding interrupt A
  logic [NPIN-1:0] mask_b_ff;          // Pins feeding interrupt B
  logic [1:0]      flag_ff;            // Sticky interrupt flags
  logic [7:0]      cfg_ff [NPIN];      // Per-pin configuration
  logic [NPIN-1:0] cfg_mask_ff;        // Multi-pin config mask
  logic [7:0]      osel_ff;            // Clock/event output select
  logic [7:0]      vmap_ff [4];        // Virtual port map
  logic [NPIN-1:0] sync1_ff;           // Synchroniser, first stage
  logic [NPIN-1:0] sync2_ff;           // Synchroniser, second stage
  logic [NPIN-1:0] prev_run_ff;        // Sample on running clock
  logic [NPIN-1:0] prev_all_ff;        // Sample on every edge
  logic            clk_div_ff;         // Clock image for the pin
  logic [7:0]      eff;                // Decoded register offset
  logic [7:0]      nxt_rdata;          // Read mux
  logic [NPIN-1:0] val;                // Pin value after inversion
  logic [NPIN-1:0] hit;                // Interrupt condition per pin
  logic [NPIN-1:0] esig;               // Signal event per pin
  logic [NPIN-1:0] wk;                 // Wake request per pin
  logic [NPIN-1:0] cfg_tgt;            // Pins hit by a config write
  logic [1:0]      flag_set;           // Flag set this cycle
  logic [1:0]      flag_clr;           // Flag clear this cycle
  logic [NPIN-1:0] nxt_out;            // Pin drive value
  logic [NPIN-1:0] nxt_oe;             // Pin drive enable

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Virtual window folds onto the real direction group
  function automatic logic [7:0] decode(input logic [7:0] a,
                                        input logic [7:0] m0, input logic [7:0] m1,
                                        input logic [7:0] m2, input logic [7:0] m3);
    logic [7:0] m;
    m = m0;
    unique case (a[3:2])
      2'h0: m = m0;
      2'h1: m = m1;
      2'h2: m = m2;
      2'h3: m = m3;
    endcase
    if (a[7:4] != OFS_VWIN[7:4]) begin
      decode = a;                                 // Plain access
    end else if (m == PORT_ID) begin
      decode = {6'h00, a[1:0]};
    end else begin
      decode = OFS_NONE;                          // Other port owns it
    end
  endfunction : decode

  assign eff = decode(reg_addr, vmap_ff[0], vmap_ff[1], vmap_ff[2], vmap_ff[3]);

  // ----------------------------------------
  // Direction register and aliases
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dir_ff <= RST_BYTE;
    end else if (reg_wr) begin
      unique case (eff)
        OFS_DIR:    dir_ff <= reg_wdata;
        OFS_DIR_SET: dir_ff <= dir_ff | reg_wdata;
        OFS_DIR_CLR: dir_ff <= dir_ff & ~reg_wdata;
        OFS_DIR_TGL: dir_ff <= dir_ff ^ reg_wdata;
        default: ;                                       // Not ours
      endcase
    end
  end

  // ----------------------------------------
  // Interrupt control registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_en_ff <= 2'h0;
      mask_a_ff <= RST_BYTE;
      mask_b_ff <= RST_BYTE;
    end else if (reg_wr) begin
      if (eff == OFS_IRQ_EN) irq_en_ff <= reg_wdata[1:0];
      if (eff == OFS_MASK_A) mask_a_ff <= reg_wdata;
      if (eff == OFS_MASK_B) mask_b_ff <= reg_wdata;
    end
  end

  // Set wins over write-one-to-clear so no event is lost
  always_comb begin
    flag_set[0] = |(hit & mask_a_ff);
    flag_set[1] = |(hit & mask_b_ff);
    flag_clr    = (reg_wr && eff == OFS_FLAGS) ? reg_wdata[1:0] : 2'h0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_ff <= 2'h0;
    end else begin
      flag_ff <= (flag_ff & ~flag_clr) | flag_set;
    end
  end

  // Request only reaches the controller once enabled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_a <= 1'b0;
      irq_b <= 1'b0;
    end else begin
      irq_a <= flag_ff[0] & irq_en_ff[0];
      irq_b <= flag_ff[1] & irq_en_ff[1];
    end
  end

  // ----------------------------------------
  // Pin configuration with multi-pin mask
  // ----------------------------------------
  always_comb begin
    cfg_tgt = '0;
    if (reg_wr && eff[7:3] == OFS_CFG_BASE[7:3]) begin
      // Empty mask means only the addressed pin
      cfg_tgt = (cfg_mask_ff != '0) ? cfg_mask_ff
                                    : (NPIN'(1) << eff[2:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NPIN; i++) cfg_ff[i] <= RST_BYTE;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        if (cfg_tgt[i]) cfg_ff[i] <= reg_wdata;
      end
    end
  end

  // Mask is spent by one config write, avoiding stale bulk writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_mask_ff <= RST_BYTE;
    end else if (reg_wr && eff == OFS_CFG_MASK) begin
      cfg_mask_ff <= reg_wdata;
    end else if (cfg_tgt != '0) begin
      cfg_mask_ff <= RST_BYTE;
    end
  end

  // Output select and virtual port map
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osel_ff <= RST_BYTE;
      for (int k = 0; k < 4; k++) vmap_ff[k] <= RST_BYTE;
    end else if (reg_wr) begin
      if (eff == OFS_OUTSEL) osel_ff <= reg_wdata;
      if (eff[7:2] == OFS_VMAP[7:2]) vmap_ff[eff[1:0]] <= reg_wdata;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    nxt_rdata = 8'h00;                            // Unmapped reads zero
    if (eff[7:2] == OFS_DIR[7:2]) begin
      nxt_rdata = dir_ff;
    end else if (eff[7:3] == OFS_CFG_BASE[7:3]) begin
      nxt_rdata = cfg_ff[eff[2:0]];
    end else if (eff[7:2] == OFS_VMAP[7:2]) begin
      nxt_rdata = vmap_ff[eff[1:0]];
    end else begin
      unique case (eff)
        OFS_IRQ_EN:   nxt_rdata = {6'h00, irq_en_ff};
        OFS_MASK_A:   nxt_rdata = mask_a_ff;
        OFS_MASK_B:   nxt_rdata = mask_b_ff;
        OFS_FLAGS:    nxt_rdata = {6'h00, flag_ff};
        OFS_CFG_MASK: nxt_rdata = cfg_mask_ff;
        OFS_OUTSEL:   nxt_rdata = osel_ff;
        default:      nxt_rdata = 8'h00;
      endcase
    end
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? nxt_rdata : 8'h00;
    end
  end

  // ----------------------------------------
  // Input sampling and sensing
  // ----------------------------------------
  // Second stage holds the first; nothing else reads stage one
  // Not cleared by reset: tracking the pins avoids a false edge at release
  always_ff @(posedge clk) begin
    sync1_ff <= pin_in;
    sync2_ff <= sync1_ff;
  end

  // Inversion turns low sensing into high sensing
  always_comb begin
    for (int i = 0; i < NPIN; i++) val[i] = sync2_ff[i] ^ cfg_ff[i][CFG_INV_BIT];
  end

  // Clocked sample freezes while stopped, so a reverted edge vanishes
  // Reset loads the live pin value so idle-high pins see no edge
  always_ff @(posedge clk) begin
    prev_all_ff <= val;
    if (!rst_n || clk_run) prev_run_ff <= val;
  end

  for (genvar g = 0; g < NPIN; g++) begin : g_pin
    ppsd_sense #(
      .FULL_ASYNC (g == FULL_ASYNC_PIN)
    ) u_sense (
      .clk      (clk),
      .rst_n    (rst_n),
      .cur      (val[g]),
      .prev_run (prev_run_ff[g]),
      .prev_all (prev_all_ff[g]),
      .clk_run  (clk_run),
      .sense    (cfg_ff[g][CFG_SNS_LSB +: 3]),
      .irq_hit  (hit[g]),
      .evt_sig  (esig[g]),
      .wake     (wk[g])
    );
  end

  // Wake only for pins that feed an interrupt
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= |(wk & (mask_a_ff | mask_b_ff));
    end
  end

  // Events, registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      evt_sig  <= '0;
      evt_data <= '0;
    end else begin
      evt_sig  <= esig;
      evt_data <= clk_run ? val : '0;
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // Flop-driven, so the clock image is half the clock rate
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_div_ff <= 1'b0;
    end else begin
      clk_div_ff <= !clk_div_ff;
    end
  end

  // Clock/event output first, then peripheral override, then port
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      nxt_oe[i]  = ovr_oe_en[i] ? ovr_oe_val[i] : dir_ff[i];
      nxt_out[i] = ovr_out_en[i] ? ovr_out_val[i] : port_out_val[i];
      if (osel_ff[OSEL_PIN_LSB +: 3] == 3'(i)) begin
        if (osel_ff[OSEL_CLK_BIT]) begin
          nxt_oe[i]  = 1'b1;
          nxt_out[i] = clk_div_ff;
        end else if (osel_ff[OSEL_EVT_BIT]) begin
          nxt_oe[i]  = 1'b1;
          nxt_out[i] = evt_ch0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      pin_out <= nxt_out;
      pin_oe  <= nxt_oe;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_DIR_RST: assert property (@(posedge clk) $rose(rst_n) |-> dir_ff == RST_BYTE)
    else $error("direction not zero after reset");
  AST_DIR_SET: assert property (reg_wr && eff == OFS_DIR_SET
    |=> dir_ff == ($past(dir_ff) | $past(reg_wdata)))
    else $error("set alias wrong");
  AST_DIR_CLR: assert property (reg_wr && eff == OFS_DIR_CLR
    |=> dir_ff == ($past(dir_ff) & ~$past(reg_wdata)))
    else $error("clear alias wrong");
  AST_DIR_TGL: assert property (reg_wr && eff == OFS_DIR_TGL
    |=> dir_ff == ($past(dir_ff) ^ $past(reg_wdata)))
    else $error("toggle alias wrong");
  AST_ALIAS_RD: assert property (reg_rd && eff[7:2] == 6'h00
    |=> reg_rdata == $past(dir_ff))
    else $error("alias read not direction");
  AST_IRQ_GATE: assert property (!irq_en_ff[0] |=> !irq_a)
    else $error("interrupt A raised while disabled");
  AST_FLAG_SET: assert property (|(hit & mask_b_ff)
    |=> flag_ff[1] ##1 (irq_b || !$past(irq_en_ff[1])))
    else $error("flag B not set on match");
  AST_LOW_HOLD: assert property (clk_run && cfg_ff[0][2:0] == SNS_LOW
    && mask_a_ff[0] && !val[0] |=> flag_ff[0])
    else $error("low level did not flag");
  AST_NO_EVT_HALT: assert property (!clk_run |=> evt_sig == 8'h00)
    else $error("event while clock stopped");
  AST_EVT_PIN: assert property (osel_ff[OSEL_EVT_BIT] && !osel_ff[OSEL_CLK_BIT]
    && osel_ff[2:0] == 3'h0 && ovr_oe_en[0] == 1'b0 |=> pin_out[0] == $past(evt_ch0))
    else $error("event not on selected pin");

  CVR_MULTI_CFG: cover property (reg_wr && eff[7:3] == 5'h02 && cfg_mask_ff != 8'h00);
  CVR_WAKE: cover property (!clk_run ##1 wake_req ##1 clk_run);
  CVR_IRQ_A: cover property (irq_a ##1 reg_wr && eff == OFS_FLAGS);

endmodule : ppsd_port
`default_nettype wire

// file: ppsd_ext_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// External circuitry on the port pins
// ----------------------------------------
module ppsd_ext_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_lvl,
  output logic      [7:0] pin_in
);
  // Device drive wins; else the bench driver, held as long as asked
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
    end
  end
endmodule : ppsd_ext_model
`default_nettype wire

// file: ppsd_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ppsd_port_tb;
  import ppsd_pkg::*;
  // ----------------------------------------
  // Stimulus and observation
  // ----------------------------------------
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       clk_run = 1'b1;
  logic       evt_ch0 = 1'b0;
  logic [7:0] port_out_val = 8'h00;
  logic [7:0] ovr_oe_en = 8'h00;
  logic [7:0] ovr_oe_val = 8'h00;
  logic [7:0] ovr_out_en = 8'h00;
  logic [7:0] ovr_out_val = 8'h00;
  logic [7:0] ext_lvl = 8'hff;
  logic [7:0] reg_rdata, pin_in, pin_out, pin_oe, evt_sig, evt_data;
  logic       irq_a, irq_b, wake_req;
  int         error_cnt = 0;
  int         total_checks = 0;

  always #2 clk = ~clk; // 250 MHz

  ppsd_port u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .port_out_val(port_out_val), .clk_run(clk_run),
    .ovr_oe_en(ovr_oe_en), .ovr_oe_val(ovr_oe_val), .ovr_out_en(ovr_out_en),
    .ovr_out_val(ovr_out_val), .evt_ch0(evt_ch0), .irq_a(irq_a), .irq_b(irq_b),
    .wake_req(wake_req), .evt_sig(evt_sig), .evt_data(evt_data));

  ppsd_ext_model u_ext (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
    .pin_in(pin_in));

  // ----------------------------------------
  // Shared bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(OFS_DIR, 8'h00);
    wr(OFS_DIR_SET, 8'h0f);
    rd(OFS_DIR_SET, 8'h0f);
    wr(OFS_DIR_CLR, 8'h05);
    rd(OFS_DIR_CLR, 8'h0a);
    wr(OFS_DIR_TGL, 8'h3c);
    rd(OFS_DIR_TGL, 8'h36);
    chk(pin_oe, 8'h36);
    wr(OFS_VMAP, PORT_ID);
    wr(8'h41, 8'h80);
    rd(OFS_DIR, 8'hb6);
    wr(8'h45, 8'h01);
    rd(OFS_DIR, 8'hb6);
    wr(OFS_DIR, 8'h00);
    rd(OFS_NONE, 8'h00);
    $display("test regs done");
  endtask : t_regs

  // Every sense code on pin 0, falling edge, interrupt A gated by enable
  task automatic t_sense;
    logic [2:0] m [4];
    logic [7:0] e;
    m = '{SNS_BOTH, SNS_RISE, SNS_FALL, SNS_LOW};
    wr(OFS_MASK_A, 8'h01);
    wr(OFS_MASK_B, 8'h02);
    wr(OFS_IRQ_EN, 8'h02);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CFG_BASE, {5'h00, m[k]});
      wr(OFS_FLAGS, 8'h03);
      @(posedge clk);
      ext_lvl[0] <= 1'b0;
      cyc(6);
      e = {7'h00, m[k] != SNS_RISE};
      rd(OFS_FLAGS, e);
      chk({7'h00, irq_a}, (k == 0) ? 8'h00 : e);
      chk({7'h00, irq_b}, 8'h00);
      wr(OFS_IRQ_EN, 8'h03);
      wr(OFS_FLAGS, 8'h01);
      cyc(2);
      rd(OFS_FLAGS, {7'h00, m[k] == SNS_LOW});
      @(posedge clk);
      ext_lvl[0] <= 1'b1;
      cyc(6);
    end
    wr(OFS_IRQ_EN, 8'h00);
    $display("test sense done");
  endtask : t_sense

  task automatic t_event;
    int n;
    n = 0;
    wr(8'h13, {5'h00, SNS_RISE});
    wr(8'h14, {5'h00, SNS_LOW});
    @(posedge clk);
    ext_lvl[3] <= 1'b0;
    cyc(6);
    ext_lvl[3] <= 1'b1;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (evt_sig[3] === 1'b1) n++;
    end
    chk(8'(n), 8'h01);
    chk({7'h00, evt_data[3]}, 8'h01);
    chk({7'h00, evt_sig[4]}, 8'h01);
    $display("test event done");
  endtask : t_event

  // Pulse while asleep: pin 2 keeps it, a limited pin loses it but wakes
  task automatic t_async;
    logic w;
    for (int p = 2; p > 0; p--) begin
      w = 1'b0;
      wr(OFS_MASK_A, 8'(1 << p));
      wr(OFS_FLAGS, 8'h03);
      @(posedge clk);
      clk_run <= 1'b0;
      cyc(2);
      ext_lvl[p] <= 1'b0;
      repeat (4) begin
        @(posedge clk);
        #1;
        if (wake_req === 1'b1) w = 1'b1;
      end
      chk(evt_data, 8'h00);
      @(posedge clk);
      ext_lvl[p] <= 1'b1;
      cyc(4);
      clk_run <= 1'b1;
      cyc(6);
      rd(OFS_FLAGS, (p == 2) ? 8'h01 : 8'h00);
      chk({7'h00, w}, 8'h01);
    end
    $display("test async done");
  endtask : t_async

  task automatic t_pins;
    logic a;
    @(posedge clk);
    ovr_oe_en <= 8'h20;
    ovr_oe_val <= 8'h20;
    ovr_out_en <= 8'h20;
    ovr_out_val <= 8'h20;
    cyc(3);
    chk(pin_oe & pin_out, 8'h20);
    ovr_oe_en <= 8'h00;
    ovr_out_en <= 8'h00;
    wr(OFS_OUTSEL, 8'h46);
    @(posedge clk);
    evt_ch0 <= 1'b1;
    @(posedge clk);
    evt_ch0 <= 1'b0;
    #1;
    chk(pin_oe & pin_out, 8'h40);
    @(posedge clk);
    #1;
    chk(pin_out & 8'h40, 8'h00);
    wr(OFS_OUTSEL, 8'h87);
    cyc(2);
    #1;
    a = pin_out[7];
    @(posedge clk);
    #1;
    chk({7'h00, pin_out[7] ^ a}, 8'h01);
    wr(OFS_OUTSEL, 8'h00);
    wr(OFS_CFG_MASK, 8'h30);
    wr(8'h14, 8'h43);
    rd(8'h15, 8'h43);
    rd(8'h16, 8'h00);
    $display("test pins done");
  endtask : t_pins

  // ----------------------------------------
  // Verdict, sequence and watchdog
  // ----------------------------------------
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  initial begin
    cyc(12);
    rst_n <= 1'b1;
    t_regs();
    t_sense();
    t_event();
    t_async();
    t_pins();
    conclude();
  end

  // Whole sequence needs well under 2000 cycles
  initial begin
    #40000;
    error_cnt++;
    conclude();
  end
endmodule : ppsd_port_tb
`default_nettype wire
